// [hdl/stc_timer.sv]
// Purpose: sixteen bit timer counter with prescaler, overflow flag and buffered access
// Assumes: registers on a plain port, read data one cycle after the read strobe
// Notes: oscillator and external clock arrive as pins and are synchronised here
//
// Behaviour
// - control bit 7 set gives buffered 16-bit access, clear gives byte access
// - control bit 6 reads 1 when system clock comes from the timer oscillator
// - bits 5-4 prescale: 11 is 1:8, 10 1:4, 01 1:2, 00 1:1
// - bit 3 enables the low-frequency oscillator, clear shuts it off
// - bit 2 clear synchronises external clock; ignored with internal clock
// - bit 1 clear counts once per instruction cycle, oscillator divided by four
// - bit 1 set counts on rising edges of external pin or oscillator
// - bit 0 set runs the counter, clear stops it
// - oscillator enabled forces both shared pins to inputs reading zero
// - the oscillator keeps running in every power-managed mode
// - counter wraps FFFFh to 0000h and sets the overflow flag
// - interrupt request only while the overflow enable bit is set
// - compare special-event mode 1011 trigger resets counter and starts conversion
// - a trigger reset never sets the overflow flag
// - a counter write in the trigger cycle wins over the reset
// - wide mode: low byte read copies the high byte into the buffer
// - wide mode: low byte write loads high byte from buffer at once
// - wide mode: high byte address reaches only the buffer
// - low byte write clears the prescaler; high byte write does not
//
// Implementation choices: the register addresses and the plain strobed port.
`include "stc_regs.svh"
module stc_timer import stc_pkg::*; #(
  parameter int OSC_DIV = `STC_INSTR_DIV  // system clocks per instruction cycle
) (
  input wire logic clk_sys,  // system clock, 200 MHz
  input wire logic rst_n,  // synchronous reset, active low
  input wire logic [`STC_ADDR_W-1:0] reg_addr,  // register address
  input wire logic [7:0] reg_wdata,  // write data
  input wire logic reg_wr,  // write strobe
  input wire logic reg_rd,  // read strobe
  output logic [7:0] reg_rdata,  // read data, valid the cycle after reg_rd
  input wire logic osc_input_pin_i,  // oscillator input pin level
  input wire logic osc_output_pin_i,  // oscillator output / external clock pin level
  input wire logic [1:0] pin_direction_bits,  // port direction bits, 1 = input
  input wire logic [1:0] port_out_bits,  // port output data for the shared pins
  input wire logic sys_clk_from_osc,  // system clock currently sourced from oscillator
  input wire logic special_event,  // compare unit trigger pulse
  input wire logic adc_enabled,  // converter is enabled
  output logic osc_amp_enable,  // oscillator inverter and feedback enable
  output logic [1:0] pin_out,  // shared pin output data
  output logic [1:0] pin_oe_n,  // shared pin output enables, low drives
  output logic [1:0] pin_read,  // port read value of the shared pins
  output logic adc_start,  // start conversion pulse
  output logic irq  // overflow interrupt request
);
  // ==========================================================
  // register state
  stc_ctrl_t ctrl;
  logic [7:0] count_low_byte;
  logic [7:0] count_high_byte;
  logic [7:0] high_buffer;
  logic overflow_flag;
  logic overflow_irq_enable;
  logic [3:0] compare_mode_select;
  logic [2:0] presc_cnt;
  logic [$clog2(OSC_DIV+1)-1:0] instr_cnt;
  logic ext_s1, ext_s2, ext_prev;
  logic osc_s1, osc_s2;
  logic run_s1, run_s2;
  logic [1:0] pin_s1, pin_s2;
  logic next_tick, ext_level, ext_rise, presc_out, inc_en;
  logic wr_low, wr_high, rd_low, trigger, osc_status;
  logic wr_count;
  logic [16:0] next_count;

  function automatic logic hit(input logic [`STC_ADDR_W-1:0] a, input logic [`STC_ADDR_W-1:0] o);
    hit = (a == o);
  endfunction

  assign wr_low = reg_wr && hit(reg_addr, `STC_OFF_COUNT_LOW);
  assign wr_high = reg_wr && hit(reg_addr, `STC_OFF_COUNT_HIGH);
  assign rd_low = reg_rd && hit(reg_addr, `STC_OFF_COUNT_LOW);
  // a high-byte write in wide mode only fills the buffer, so the counter still moves
  assign wr_count = wr_low || (wr_high && !ctrl.wide_access_enable);
  assign trigger = special_event && (compare_mode_select == `STC_CMP_SPECIAL_EVENT);

  // ==========================================================
  // control register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl <= stc_ctrl_t'(7'h00);
      overflow_irq_enable <= 1'b0;
      compare_mode_select <= 4'h0;
    end else if (reg_wr) begin
      if (hit(reg_addr, `STC_OFF_CONTROL)) begin
        ctrl.wide_access_enable <= reg_wdata[`STC_BIT_WIDE];
        ctrl.input_prescale_select <= reg_wdata[`STC_BIT_PRESC_HI:`STC_BIT_PRESC_LO];
        ctrl.low_freq_osc_enable <= reg_wdata[`STC_BIT_OSC_EN];
        ctrl.ext_sync_disable <= reg_wdata[`STC_BIT_SYNC_DIS];
        ctrl.clock_source_select <= reg_wdata[`STC_BIT_CLK_SEL];
        ctrl.counter_run <= reg_wdata[`STC_BIT_RUN];
      end
      if (hit(reg_addr, `STC_OFF_ENABLE)) begin
        overflow_irq_enable <= reg_wdata[0];
      end
      if (hit(reg_addr, `STC_OFF_COMPARE_MODE)) begin
        compare_mode_select <= reg_wdata[3:0];
      end
    end
  end

  // ==========================================================
  // clock sources
  // oscillator output runs free of power modes; only its enable gates it
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      osc_amp_enable <= 1'b0;
    end else begin
      osc_amp_enable <= ctrl.low_freq_osc_enable;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      run_s1 <= 1'b0;
      run_s2 <= 1'b0;
      pin_s1 <= 2'h0;
      pin_s2 <= 2'h0;
      ext_prev <= 1'b0;
    end else begin
      ext_s1 <= osc_output_pin_i;
      ext_s2 <= ext_s1;
      osc_s1 <= osc_input_pin_i;
      osc_s2 <= osc_s1;
      run_s1 <= sys_clk_from_osc;
      run_s2 <= run_s1;
      pin_s1 <= {osc_input_pin_i, osc_output_pin_i};
      pin_s2 <= pin_s1;
      ext_prev <= ext_level;
    end
  end

  // with the oscillator enabled the oscillator node is the count source
  assign ext_level = ctrl.low_freq_osc_enable ? osc_s2 : ext_s2;
  assign ext_rise = ext_level && !ext_prev;
  assign osc_status = run_s2;

  // instruction cycle divider: one enable pulse every OSC_DIV system clocks
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      instr_cnt <= '0;
    end else if (instr_cnt == ($bits(instr_cnt))'(OSC_DIV - 1)) begin
      instr_cnt <= '0;
    end else begin
      instr_cnt <= instr_cnt + 1'b1;
    end
  end

  // unsynchronised mode is modelled by the same sampled edge; a true asynchronous
  // path would need a second clock domain, which this block does not have
  always_comb begin
    if (ctrl.clock_source_select) begin
      next_tick = ext_rise;
    end else begin
      next_tick = (instr_cnt == ($bits(instr_cnt))'(OSC_DIV - 1));
    end
  end

  // ==========================================================
  // prescaler
  always_comb begin
    case (ctrl.input_prescale_select)
      2'h0: presc_out = next_tick;
      2'h1: presc_out = next_tick && (presc_cnt[0] == 1'b1);
      2'h2: presc_out = next_tick && (presc_cnt[1:0] == 2'h3);
      2'h3: presc_out = next_tick && (presc_cnt == 3'h7);
      default: presc_out = 1'b0;
    endcase
  end
  assign inc_en = presc_out && ctrl.counter_run;

  always_ff @(posedge clk_sys) begin
    if (!rst_n || wr_low) begin
      presc_cnt <= 3'h0;
    end else if (next_tick && ctrl.counter_run) begin
      presc_cnt <= presc_cnt + 3'h1;
    end
  end

  // ==========================================================
  // counter, buffer and overflow
  assign next_count = {1'b0, count_high_byte, count_low_byte} + 17'h00001;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      {count_high_byte, count_low_byte} <= `STC_RST_COUNT;
    end else if (wr_low) begin
      count_low_byte <= reg_wdata;
      if (ctrl.wide_access_enable) begin
        count_high_byte <= high_buffer;
      end
    end else if (wr_high && !ctrl.wide_access_enable) begin
      count_high_byte <= reg_wdata;
    end else if (trigger) begin
      {count_high_byte, count_low_byte} <= `STC_RST_COUNT;
    end else if (inc_en) begin
      {count_high_byte, count_low_byte} <= next_count[15:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      high_buffer <= 8'h00;
    end else if (wr_high && ctrl.wide_access_enable) begin
      high_buffer <= reg_wdata;
    end else if (rd_low && ctrl.wide_access_enable) begin
      high_buffer <= count_high_byte;
    end
  end

  // set wins over a software clear; trigger resets never set it
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      overflow_flag <= 1'b0;
    end else if (inc_en && next_count[16] && !trigger && !wr_count) begin
      overflow_flag <= 1'b1;
    end else if (reg_wr && hit(reg_addr, `STC_OFF_FLAG)) begin
      overflow_flag <= reg_wdata[0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq <= 1'b0;
      adc_start <= 1'b0;
    end else begin
      irq <= overflow_flag && overflow_irq_enable;
      adc_start <= trigger && adc_enabled && !wr_count;
    end
  end

  // ==========================================================
  // shared pins
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pin_out <= 2'h0;
      pin_oe_n <= 2'h3;
      pin_read <= 2'h0;
    end else begin
      pin_out <= port_out_bits;
      pin_oe_n <= ctrl.low_freq_osc_enable ? 2'h3 : pin_direction_bits;
      pin_read <= ctrl.low_freq_osc_enable ? 2'h0 : pin_s2;
    end
  end

  // ==========================================================
  // read port
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `STC_OFF_CONTROL: reg_rdata <= {ctrl.wide_access_enable, osc_status,
          ctrl.input_prescale_select, ctrl.low_freq_osc_enable,
          ctrl.ext_sync_disable, ctrl.clock_source_select, ctrl.counter_run};
        `STC_OFF_COUNT_LOW: reg_rdata <= count_low_byte;
        `STC_OFF_COUNT_HIGH: reg_rdata <= ctrl.wide_access_enable ? high_buffer
          : count_high_byte;
        `STC_OFF_FLAG: reg_rdata <= {7'h00, overflow_flag};
        `STC_OFF_ENABLE: reg_rdata <= {7'h00, overflow_irq_enable};
        `STC_OFF_COMPARE_MODE: reg_rdata <= {4'h0, compare_mode_select};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ==========================================================
  // checks
  property p_wrap_sets_flag;
    @(posedge clk_sys) disable iff (!rst_n)
      (inc_en && ({count_high_byte, count_low_byte} == 16'hffff) && !trigger && !wr_count)
      |=> overflow_flag;
  endproperty
  a_wrap_sets_flag: assert property (p_wrap_sets_flag) else $error("wrap lost flag");

  property p_trigger_no_flag;
    @(posedge clk_sys) disable iff (!rst_n)
      (trigger && !wr_low && !wr_high && !overflow_flag && !reg_wr) |=> !overflow_flag;
  endproperty
  a_trigger_no_flag: assert property (p_trigger_no_flag) else $error("trigger set flag");

  property p_trigger_clears;
    @(posedge clk_sys) disable iff (!rst_n)
      (trigger && !reg_wr) |=> ({count_high_byte, count_low_byte} == 16'h0000);
  endproperty
  a_trigger_clears: assert property (p_trigger_clears) else $error("trigger no reset");

  property p_write_wins;
    @(posedge clk_sys) disable iff (!rst_n)
      (trigger && wr_low) |=> (count_low_byte == $past(reg_wdata));
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("trigger beat write");

  property p_irq_gated;
    @(posedge clk_sys) disable iff (!rst_n)
      irq |-> $past(overflow_irq_enable) && $past(overflow_flag);
  endproperty
  a_irq_gated: assert property (p_irq_gated) else $error("irq without enable");

  property p_stopped;
    @(posedge clk_sys) disable iff (!rst_n)
      (!ctrl.counter_run && !reg_wr && !trigger) |=> $stable({count_high_byte, count_low_byte});
  endproperty
  a_stopped: assert property (p_stopped) else $error("counted while stopped");

  property p_buffer_snap;
    @(posedge clk_sys) disable iff (!rst_n)
      (rd_low && ctrl.wide_access_enable) |=> (high_buffer == $past(count_high_byte));
  endproperty
  a_buffer_snap: assert property (p_buffer_snap) else $error("buffer not loaded");

  property p_wide_load;
    @(posedge clk_sys) disable iff (!rst_n)
      (wr_low && ctrl.wide_access_enable) |=> (count_high_byte == $past(high_buffer));
  endproperty
  a_wide_load: assert property (p_wide_load) else $error("high not loaded");

  property p_presc_clear;
    @(posedge clk_sys) disable iff (!rst_n)
      wr_low |=> (presc_cnt == 3'h0);
  endproperty
  a_presc_clear: assert property (p_presc_clear) else $error("prescaler kept");

  property p_pins_input;
    @(posedge clk_sys) disable iff (!rst_n)
      ctrl.low_freq_osc_enable |=> (pin_oe_n == 2'h3) && (pin_read == 2'h0);
  endproperty
  a_pins_input: assert property (p_pins_input) else $error("pins not inputs");

  c_wrap: cover property (@(posedge clk_sys) disable iff (!rst_n) inc_en && next_count[16]);
  c_trigger: cover property (@(posedge clk_sys) disable iff (!rst_n) trigger);
  c_wide_read: cover property (@(posedge clk_sys) disable iff (!rst_n)
    rd_low && ctrl.wide_access_enable);
  c_collide: cover property (@(posedge clk_sys) disable iff (!rst_n) trigger && wr_low);
endmodule

// [inc/stc_regs.svh]
`ifndef STC_REGS_SVH
`define STC_REGS_SVH
// register offsets on the plain register port
`define STC_ADDR_W 3
`define STC_OFF_CONTROL 3'h0
`define STC_OFF_COUNT_LOW 3'h1
`define STC_OFF_COUNT_HIGH 3'h2
`define STC_OFF_FLAG 3'h3
`define STC_OFF_ENABLE 3'h4
`define STC_OFF_COMPARE_MODE 3'h5
// control field positions
`define STC_BIT_WIDE 7
`define STC_BIT_OSC_STATUS 6
`define STC_BIT_PRESC_HI 5
`define STC_BIT_PRESC_LO 4
`define STC_BIT_OSC_EN 3
`define STC_BIT_SYNC_DIS 2
`define STC_BIT_CLK_SEL 1
`define STC_BIT_RUN 0
// reset values
`define STC_RST_CONTROL 8'h00
`define STC_RST_COUNT 16'h0000
// compare mode code that resets the counter
`define STC_CMP_SPECIAL_EVENT 4'hb
// instruction cycle is the oscillator divided by four
`define STC_INSTR_DIV 4
`endif

// [inc/stc_pkg.sv]
// Purpose: types shared by the sixteen bit timer counter
// Assumes: stc_regs.svh holds the numbers
// Notes: none
package stc_pkg;
  typedef struct packed {
    logic wide_access_enable;
    logic [1:0] input_prescale_select;
    logic low_freq_osc_enable;
    logic ext_sync_disable;
    logic clock_source_select;
    logic counter_run;
  } stc_ctrl_t;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } stc_bus_t;
endpackage

// [dv/stc_clk_src.sv]
// Purpose: far-side clock source, external clock pin or crystal
// Assumes: the bench calls burst while the counter listens
// Notes: both clock pins stand low between bursts, never free-running
module stc_clk_src (
  input wire logic osc_on,  // crystal amplifier enabled by the block
  output logic ext_pin,  // external clock pin
  output logic osc_pin  // crystal input pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ext_pin = 1'b0;
    osc_pin = 1'b0;
  end
  // half period in ns; a slow half lets the synchroniser see every edge
  task automatic burst(input int n, input int half);
    // step off the sampling edge so no pin moves in the same step as clk_sys
    #1;
    for (int i = 0; i < n; i++) begin
      if (osc_on) begin
        osc_pin = 1'b1;
      end else begin
        ext_pin = 1'b1;
      end
      #(half);
      osc_pin = 1'b0;
      ext_pin = 1'b0;
      #(half);
    end
  endtask
endmodule

// [dv/stc_timer_tb.sv]
// Purpose: self-checking bench for the sixteen bit timer counter
// Assumes: OSC_DIV set to 2 so internal ticks come every 2 clocks
// Notes: reads are scored from a queue of expected ranges
`include "stc_regs.svh"
`define TB_CHK(got, exp, msg) begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("BAD %0t %s", $time, msg); \
    end \
  end
module stc_timer_tb import stc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = 2;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [1:0] dir = 2'h3;
  logic [1:0] pout = 2'h0;
  logic osc_sys = 1'b0;
  logic special_event = 1'b0;
  logic adc_enabled = 1'b0;
  logic rd_q = 1'b0;
  logic [7:0] reg_rdata, lo, hi;
  logic osc_amp_enable, adc_start, irq, ext_pin, osc_pin;
  logic [1:0] pin_out, pin_oe_n, pin_read;
  logic [15:0] exp_q[$];
  int n_mismatch = 0;
  int num_checks = 0;
  int seed = 97;

  always #2.5 clk_sys = ~clk_sys;

  stc_timer #(.OSC_DIV(DIV)) stc_timer_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .osc_input_pin_i(osc_pin), .osc_output_pin_i(ext_pin),
    .pin_direction_bits(dir), .port_out_bits(pout), .sys_clk_from_osc(osc_sys),
    .special_event(special_event), .adc_enabled(adc_enabled),
    .osc_amp_enable(osc_amp_enable), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_read(pin_read), .adc_start(adc_start), .irq(irq)
  );
  stc_clk_src stc_clk_src_inst (.osc_on(osc_amp_enable), .ext_pin(ext_pin), .osc_pin(osc_pin));

  // ==========================================================
  // bus tasks and read scoreboard
  task automatic op(input logic [2:0] a, input logic [7:0] d, input logic w, input logic se);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    special_event <= se;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    special_event <= 1'b0;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    op(a, d, 1'b1, 1'b0);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] l, input logic [7:0] h);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back({l, h});
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask
  task automatic rd1(input logic [2:0] a, input logic [7:0] v);
    rd(a, v, v);
  endtask
  // trigger, optionally beside a low-byte write; counts conversion starts
  task automatic trig(input logic w, input int exp_adc);
    int seen;
    seen = 0;
    op(3'h1, 8'h55, w, 1'b1);
    repeat (3) begin
      #1;
      if (adc_start !== 1'b0) seen++;
      @(posedge clk_sys);
    end
    `TB_CHK(seen, exp_adc, "conversion start count")
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    if (rd_q) begin
      {lo, hi} = exp_q.pop_front();
      `TB_CHK(reg_rdata >= lo && reg_rdata <= hi, 1'b1, "read data")
    end
    rd_q <= reg_rd;
  end

  // ==========================================================
  // main sequence
  initial begin
    int k;
    logic [7:0] a, b;
    logic [7:0] m [3];
    m = '{8'h03, 8'h07, 8'h0b};
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd1(3'h0, 8'h00);
    rd1(3'h1, 8'h00);
    rd1(3'h3, 8'h00);
    done("reset");
    wr(3'h0, 8'hff);
    rd1(3'h0, 8'hbf);
    osc_sys <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd1(3'h0, 8'hff);
    wr(3'h0, 8'h00);
    wr(3'h7, 8'hff);
    rd1(3'h7, 8'h00);
    done("control");
    for (k = 0; k < 2; k++) begin
      a = $random(seed);
      b = $random(seed);
      wr(3'h2, a);
      wr(3'h1, b);
      rd1(3'h2, a);
      wr(3'h2, ~a);
      rd1(3'h1, b);
      rd1(3'h2, ~a);
    end
    wr(3'h0, 8'h80);
    wr(3'h2, a);
    rd1(3'h2, a);
    rd1(3'h1, b);
    rd1(3'h2, ~a);
    wr(3'h2, 8'h3c);
    wr(3'h1, 8'hc3);
    wr(3'h0, 8'h00);
    rd1(3'h2, 8'h3c);
    rd1(3'h1, 8'hc3);
    done("access");
    // run window is exactly 5 prescaled periods, so the count is exact
    for (k = 0; k < 4; k++) begin
      wr(3'h1, 8'h00);
      wr(3'h2, 8'h00);
      wr(3'h0, {2'b00, k[1:0], 4'h1});
      repeat (DIV * (1 << k) * 5 - 2) @(posedge clk_sys);
      wr(3'h0, 8'h00);
      rd1(3'h1, 8'h05);
    end
    done("prescale");
    for (k = 1; k >= 0; k--) begin
      wr(3'h4, k[7:0]);
      wr(3'h2, 8'hff);
      wr(3'h1, 8'hfe);
      wr(3'h0, 8'h01);
      for (int i = 0; i < 40 && irq !== 1'b1; i++) @(posedge clk_sys);
      `TB_CHK(irq, k[0], "overflow request")
      wr(3'h0, 8'h00);
      rd1(3'h3, 8'h01);
      rd1(3'h2, 8'h00);
      wr(3'h3, 8'h00);
      repeat (3) @(posedge clk_sys);
      `TB_CHK(irq, 1'b0, "request after clear")
    end
    // wide mode: a wrap beside back-to-back buffer writes still sets the flag
    wr(3'h0, 8'h80);
    wr(3'h2, 8'hff);
    wr(3'h1, 8'hfe);
    wr(3'h0, 8'h81);
    @(posedge clk_sys);
    reg_addr <= 3'h2;
    reg_wdata <= 8'h12;
    reg_wr <= 1'b1;
    repeat (8) @(posedge clk_sys);
    reg_wr <= 1'b0;
    wr(3'h0, 8'h00);
    rd1(3'h3, 8'h01);
    rd1(3'h2, 8'h00);
    wr(3'h3, 8'h00);
    done("overflow");
    // timer mode only: trigger resets are unreliable unsynchronised
    wr(3'h4, 8'h00);
    wr(3'h2, 8'hff);
    wr(3'h1, 8'hff);
    adc_enabled <= 1'b1;
    wr(3'h5, 8'h0a);
    trig(1'b0, 0);
    rd1(3'h1, 8'hff);
    wr(3'h5, 8'h0b);
    trig(1'b0, 1);
    rd1(3'h1, 8'h00);
    rd1(3'h2, 8'h00);
    rd1(3'h3, 8'h00);
    trig(1'b1, 0);
    rd1(3'h1, 8'h55);
    adc_enabled <= 1'b0;
    trig(1'b0, 0);
    done("trigger");
    dir <= $random(seed);
    pout <= $random(seed);
    repeat (3) @(posedge clk_sys);
    `TB_CHK(pin_oe_n, dir, "pin enables")
    `TB_CHK(pin_out, pout, "pin data")
    `TB_CHK(osc_amp_enable, 1'b0, "amplifier off")
    wr(3'h0, 8'h08);
    repeat (3) @(posedge clk_sys);
    `TB_CHK(osc_amp_enable, 1'b1, "amplifier on")
    `TB_CHK(pin_oe_n, 2'h3, "pins forced to input")
    `TB_CHK(pin_read, 2'h0, "pins read zero")
    done("pins");
    for (k = 0; k < 3; k++) begin
      wr(3'h0, 8'h00);
      wr(3'h1, 8'h00);
      wr(3'h0, m[k]);
      repeat (3) @(posedge clk_sys);
      stc_clk_src_inst.burst(6, 20);
      repeat (8) @(posedge clk_sys);
      rd1(3'h1, 8'h06);
    end
    done("external");
    repeat (3) @(posedge clk_sys);
    stop_test();
  end
endmodule
